// ---- hdl/sios_cfg_if.sv ----
// carrier between the register bank and the stage field decoder
`timescale 1ns/1ps
interface sios_cfg_if;
   logic [15:0] route_high;
   logic [15:0] offset;
   logic [15:0] sens;
   sios_pkg::sios_stage_cfg_t cfg;

   modport bank (output route_high, output offset, output sens, input cfg);
   modport dec (input route_high, input offset, input sens, output cfg);
endinterface

// ---- hdl/sios_params.svh ----
// constants for the stage input, offset and sensitivity register bank
`ifndef SIOS_PARAMS_SVH
`define SIOS_PARAMS_SVH

// ****************************************************************
// register map (word indices; byte address is four times the index)
// ****************************************************************
`define SIOS_STAGE_BASE_IDX 12'h080
`define SIOS_STAGE1_BASE_IDX 12'h088
`define SIOS_NUM_STAGES 12
`define SIOS_SLOT_ROUTE_HIGH 3'h1
`define SIOS_SLOT_OFFSET 3'h2
`define SIOS_SLOT_SENS 3'h3
`define SIOS_REG_RESET 16'h0000

// ****************************************************************
// route register fields
// ****************************************************************
`define SIOS_ROUTE_FIELD_W 2
`define SIOS_SE_LSB 12
`define SIOS_MINUS_OFF_BIT 14
`define SIOS_PLUS_OFF_BIT 15
`define SIOS_ROUTE_MASK 16'hffff

// ****************************************************************
// offset register fields
// ****************************************************************
`define SIOS_MINUS_CODE_LSB 0
`define SIOS_MINUS_STEER_BIT 7
`define SIOS_PLUS_CODE_LSB 8
`define SIOS_PLUS_STEER_BIT 15
`define SIOS_OFFSET_MASK 16'hbfbf
`define SIOS_OFFSET_STEP_FF 320

// ****************************************************************
// sensitivity register fields
// ****************************************************************
`define SIOS_MINUS_THR_LSB 0
`define SIOS_MINUS_PEAK_LSB 4
`define SIOS_PLUS_THR_LSB 8
`define SIOS_PLUS_PEAK_LSB 12
`define SIOS_SENS_MASK 16'h7f7f
`define SIOS_PEAK_BASE_PCT 40
`define SIOS_PEAK_STEP_PCT 10
`define SIOS_PEAK_MAX_CODE 3'h5

// ****************************************************************
// bus encodings
// ****************************************************************
`define SIOS_HTRANS_NONSEQ 2'h2
`define SIOS_HRESP_OKAY 1'b0

`endif

// ---- hdl/sios_pkg.sv ----
// types shared by the stage register bank and its field decoder
package sios_pkg;

   typedef enum logic [1:0] {
      SIOS_ROUTE_OPEN = 2'h0,
      SIOS_ROUTE_NEG = 2'h1,
      SIOS_ROUTE_POS = 2'h2,
      SIOS_ROUTE_BIAS = 2'h3
   } sios_route_t;

   typedef enum logic [1:0] {
      SIOS_SE_ILLEGAL = 2'h0,
      SIOS_SE_POS = 2'h1,
      SIOS_SE_NEG = 2'h2,
      SIOS_SE_DIFF = 2'h3
   } sios_se_mode_t;

   // bit i of each mask stands for sense input 7+i
   typedef struct packed {
      logic [5:0] pos_mask;
      logic [5:0] neg_mask;
      logic [5:0] bias_mask;
      sios_se_mode_t single_ended_mode_sel;
      logic diff;
      logic minus_on;
      logic [5:0] minus_offset_code;
      logic [14:0] minus_offset_ff;
      logic minus_to_pos;
      logic plus_on;
      logic [5:0] plus_offset_code;
      logic [14:0] plus_offset_ff;
      logic plus_to_neg;
      logic [13:0] minus_threshold_level;
      logic [13:0] plus_threshold_level;
      logic [6:0] minus_peak_level;
      logic [6:0] plus_peak_level;
      logic minus_peak_ok;
      logic plus_peak_ok;
   } sios_stage_cfg_t;

endpackage

// ---- hdl/sios_regs.sv ----
// per-stage input route, front end offset and threshold registers on ahb-lite
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "sios_params.svh"

// Contract
// - each input 7-12 route field: 00 open, 01 negative, 10 positive, 11 bias.
// - route fields sit in ascending bit pairs, input 7 at [1:0] to 12 at [11:10].
// - single-ended field value 11 selects a differential measurement.
// - route bit 14 low enables the negative offset, high disables it.
// - route bit 15 low enables the positive offset, high disables it.
// - offset bits [5:0] are the negative offset code, 0.32 pF per step.
// - offset bits [13:8] are the positive offset code, same step and span.
// - offset bit 7 steers negative offset to negative or positive input.
// - offset bit 15 steers positive offset to positive or negative input.
// - sensitivity bits [3:0] pick negative threshold, 25% up to 95.32%.
// - sensitivity bits [11:8] pick positive threshold from the same table.
// - threshold table fixes each code, e.g. 0001 29.73%, 1000 62.51%.
// - sensitivity bits [6:4] set negative peak level, 40% to 90% by 10%.
// - sensitivity bits [14:12] set positive peak level, same encoding.
// - stage s owns eight registers from 0x080+8s; slots 1, 2, 3 here.
module sios_regs #(
   parameter int NUM_STAGES = `SIOS_NUM_STAGES
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [3:0] stage_sel,
   output logic [3:0] stage_cfg_idx,
   output sios_pkg::sios_stage_cfg_t stage_cfg
);

   // ****************************************************************
   // address decode
   // ****************************************************************
   typedef struct packed {
      logic hit;
      logic [3:0] stage;
      logic [2:0] slot;
   } sios_dec_t;

   // a stage index is only backed by storage below NUM_STAGES
   function automatic logic sios_stage_ok(input logic [3:0] s);
      return int'(s) < NUM_STAGES;
   endfunction

   // stage base is aligned to eight words, so stage and slot are plain slices
   function automatic sios_dec_t sios_decode(input logic [11:0] idx);
      sios_dec_t d;
      logic [11:0] rel;
      logic in_window;
      logic slot_ours;
      rel = idx - `SIOS_STAGE_BASE_IDX;
      d.stage = rel[6:3];
      d.slot = rel[2:0];
      in_window = (idx >= `SIOS_STAGE_BASE_IDX) && (rel[11:7] == 5'h00) &&
                  sios_stage_ok(rel[6:3]);
      slot_ours = (rel[2:0] == `SIOS_SLOT_ROUTE_HIGH) || (rel[2:0] == `SIOS_SLOT_OFFSET) ||
                  (rel[2:0] == `SIOS_SLOT_SENS);
      d.hit = in_window && slot_ours;
      return d;
   endfunction

   // writable bits of each register, built from the field positions so that
   // a moved field moves its mask with it
   function automatic logic [15:0] sios_route_bits();
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         m[i*`SIOS_ROUTE_FIELD_W +: `SIOS_ROUTE_FIELD_W] = 2'h3;
      end
      m[`SIOS_SE_LSB +: 2] = 2'h3;
      m[`SIOS_MINUS_OFF_BIT] = 1'b1;
      m[`SIOS_PLUS_OFF_BIT] = 1'b1;
      return m;
   endfunction

   function automatic logic [15:0] sios_offset_bits();
      logic [15:0] m;
      m = 16'h0000;
      m[`SIOS_MINUS_CODE_LSB +: 6] = 6'h3f;
      m[`SIOS_MINUS_STEER_BIT] = 1'b1;
      m[`SIOS_PLUS_CODE_LSB +: 6] = 6'h3f;
      m[`SIOS_PLUS_STEER_BIT] = 1'b1;
      return m;
   endfunction

   function automatic logic [15:0] sios_sens_bits();
      logic [15:0] m;
      m = 16'h0000;
      m[`SIOS_MINUS_THR_LSB +: 4] = 4'hf;
      m[`SIOS_MINUS_PEAK_LSB +: 3] = 3'h7;
      m[`SIOS_PLUS_THR_LSB +: 4] = 4'hf;
      m[`SIOS_PLUS_PEAK_LSB +: 3] = 3'h7;
      return m;
   endfunction

   // unused bits are dropped on write, so they read back as zero
   function automatic logic [15:0] sios_wmask(input logic [2:0] slot);
      logic [15:0] m;
      m = 16'h0000;
      if (slot == `SIOS_SLOT_ROUTE_HIGH) begin
         m = sios_route_bits();
      end else if (slot == `SIOS_SLOT_OFFSET) begin
         m = sios_offset_bits();
      end else if (slot == `SIOS_SLOT_SENS) begin
         m = sios_sens_bits();
      end
      return m;
   endfunction

   // ****************************************************************
   // storage
   // ****************************************************************
   // one full 16-bit word per stage and slot; unused bits are stored as zero
   logic [15:0] route_high_r [NUM_STAGES];
   logic [15:0] offset_r [NUM_STAGES];
   logic [15:0] sens_r [NUM_STAGES];

   // ****************************************************************
   // ahb-lite data phase tracking
   // ****************************************************************
   logic dp_valid_r;
   logic dp_write_r;
   sios_dec_t dp_dec_r;
   sios_dec_t ap_dec;
   logic ap_take;
   logic wr_now;
   logic [15:0] wr_val;
   logic wr_route;
   logic wr_offset;
   logic wr_sens;
   logic fwd_hit;
   logic rd_take;

   assign ap_take = hsel && hready && (htrans == `SIOS_HTRANS_NONSEQ);
   assign ap_dec = sios_decode(haddr[13:2]);
   // zero wait states: every transfer completes in its first data phase
   assign hreadyout = 1'b1;
   // unmapped words are answered okay too; their reads return zero
   assign hresp = `SIOS_HRESP_OKAY;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dp_valid_r <= 1'b0;
      end else begin
         dp_valid_r <= ap_take;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dp_write_r <= 1'b0;
      end else begin
         dp_write_r <= ap_take && hwrite;
      end
   end

   // cleared between transfers so a stale hit can never strobe a write
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dp_dec_r <= '0;
      end else begin
         dp_dec_r <= ap_take ? ap_dec : '0;
      end
   end

   // hsize is not checked: only whole-word transfers are supported
   assign wr_now = dp_valid_r && dp_write_r && dp_dec_r.hit;
   assign wr_val = hwdata[15:0] & sios_wmask(dp_dec_r.slot);
   // one strobe per register kind, so each storage process keeps to its own word
   assign wr_route = wr_now && (dp_dec_r.slot == `SIOS_SLOT_ROUTE_HIGH);
   assign wr_offset = wr_now && (dp_dec_r.slot == `SIOS_SLOT_OFFSET);
   assign wr_sens = wr_now && (dp_dec_r.slot == `SIOS_SLOT_SENS);
   // a read taken while a write to the same word is in its data phase
   assign fwd_hit = wr_now && ap_dec.hit && (ap_dec.stage == dp_dec_r.stage) &&
      (ap_dec.slot == dp_dec_r.slot);
   assign rd_take = ap_take && !hwrite;

   // ****************************************************************
   // register writes
   // ****************************************************************
   // contents after reset are not meaningful to software; zero is only
   // chosen so the decoded outputs are defined
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int s = 0; s < NUM_STAGES; s++) begin
            route_high_r[s] <= `SIOS_REG_RESET;
         end
      end else if (wr_route) begin
         route_high_r[dp_dec_r.stage] <= wr_val;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int s = 0; s < NUM_STAGES; s++) begin
            offset_r[s] <= `SIOS_REG_RESET;
         end
      end else if (wr_offset) begin
         offset_r[dp_dec_r.stage] <= wr_val;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int s = 0; s < NUM_STAGES; s++) begin
            sens_r[s] <= `SIOS_REG_RESET;
         end
      end else if (wr_sens) begin
         sens_r[dp_dec_r.stage] <= wr_val;
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   function automatic logic [15:0] sios_read(input sios_dec_t d);
      logic [15:0] v;
      v = 16'h0000;
      if (d.hit) begin
         if (d.slot == `SIOS_SLOT_ROUTE_HIGH) begin
            v = route_high_r[d.stage];
         end else if (d.slot == `SIOS_SLOT_OFFSET) begin
            v = offset_r[d.stage];
         end else begin
            v = sens_r[d.stage];
         end
      end
      return v;
   endfunction

   // read data is captured in the address phase; a write in its data
   // phase to the same word is forwarded so back-to-back access stays coherent
   logic [15:0] rd_nxt;
   logic [15:0] rd_r;

   always_comb begin
      rd_nxt = sios_read(ap_dec);
      if (fwd_hit) begin
         rd_nxt = wr_val;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_r <= 16'h0000;
      end else if (rd_take) begin
         rd_r <= rd_nxt;
      end
   end

   assign hrdata = {16'h0000, rd_r};

   // ****************************************************************
   // stage configuration for the sequencer
   // ****************************************************************
   sios_cfg_if cfg_bus ();
   logic [3:0] sel_safe;

   // out-of-range selects fall back to stage zero rather than reading past the array
   assign sel_safe = sios_stage_ok(stage_sel) ? stage_sel : 4'h0;
   assign cfg_bus.route_high = route_high_r[sel_safe];
   assign cfg_bus.offset = offset_r[sel_safe];
   assign cfg_bus.sens = sens_r[sel_safe];

   sios_stage_decode u_decode (
      .cfg_io(cfg_bus.dec)
   );

   // one cycle of latency; the sequencer may not rely on peak levels
   // for undefined codes, flagged by the peak ok bits
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_cfg <= '0;
      end else begin
         stage_cfg <= cfg_bus.cfg;
      end
   end

   // tells the sequencer which stage it got, since far selects are folded
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_cfg_idx <= 4'h0;
      end else begin
         stage_cfg_idx <= sel_safe;
      end
   end

endmodule

// ---- hdl/sios_stage_decode.sv ----
// decodes one stage's three raw registers into analog front end settings
`timescale 1ns/1ps
`include "sios_params.svh"
module sios_stage_decode (
   sios_cfg_if.dec cfg_io
);

   // ****************************************************************
   // lookup functions
   // ****************************************************************
   // threshold level in hundredths of a percent
   function automatic logic [13:0] sios_thr_pct(input logic [3:0] code);
      logic [13:0] v;
      v = 14'h0000;
      case (code)
         4'h0: v = 14'd2500;
         4'h1: v = 14'd2973;
         4'h2: v = 14'd3440;
         4'h3: v = 14'd3908;
         4'h4: v = 14'd4379;
         4'h5: v = 14'd4847;
         4'h6: v = 14'd5315;
         4'h7: v = 14'd5783;
         4'h8: v = 14'd6251;
         4'h9: v = 14'd6722;
         4'ha: v = 14'd7190;
         4'hb: v = 14'd7658;
         4'hc: v = 14'd8128;
         4'hd: v = 14'd8596;
         4'he: v = 14'd9064;
         default: v = 14'd9532;
      endcase
      return v;
   endfunction

   // peak level in percent; undefined codes give zero
   function automatic logic [6:0] sios_peak_pct(input logic [2:0] code);
      logic [6:0] v;
      v = 7'h00;
      if (code <= `SIOS_PEAK_MAX_CODE) begin
         v = 7'(`SIOS_PEAK_BASE_PCT + `SIOS_PEAK_STEP_PCT * int'(code));
      end
      return v;
   endfunction

   function automatic logic [14:0] sios_offset_ff(input logic [5:0] code);
      return 15'(int'(code) * `SIOS_OFFSET_STEP_FF);
   endfunction

   // ****************************************************************
   // field decode
   // ****************************************************************
   always_comb begin
      logic [1:0] f;
      logic [5:0] mc;
      logic [5:0] pc;
      f = 2'h0;
      mc = cfg_io.offset[`SIOS_MINUS_CODE_LSB +: 6];
      pc = cfg_io.offset[`SIOS_PLUS_CODE_LSB +: 6];
      cfg_io.cfg = '0;
      for (int i = 0; i < 6; i++) begin
         f = cfg_io.route_high[i*`SIOS_ROUTE_FIELD_W +: `SIOS_ROUTE_FIELD_W];
         cfg_io.cfg.neg_mask[i] = (f == sios_pkg::SIOS_ROUTE_NEG);
         cfg_io.cfg.pos_mask[i] = (f == sios_pkg::SIOS_ROUTE_POS);
         cfg_io.cfg.bias_mask[i] = (f == sios_pkg::SIOS_ROUTE_BIAS);
      end
      cfg_io.cfg.single_ended_mode_sel =
         sios_pkg::sios_se_mode_t'(cfg_io.route_high[`SIOS_SE_LSB +: 2]);
      cfg_io.cfg.diff = (cfg_io.route_high[`SIOS_SE_LSB +: 2] == sios_pkg::SIOS_SE_DIFF);
      // disable bits are active high, so the enable is the inverse
      cfg_io.cfg.minus_on = !cfg_io.route_high[`SIOS_MINUS_OFF_BIT];
      cfg_io.cfg.plus_on = !cfg_io.route_high[`SIOS_PLUS_OFF_BIT];
      cfg_io.cfg.minus_offset_code = mc;
      cfg_io.cfg.minus_offset_ff = sios_offset_ff(mc);
      cfg_io.cfg.plus_offset_code = pc;
      cfg_io.cfg.plus_offset_ff = sios_offset_ff(pc);
      cfg_io.cfg.minus_to_pos = cfg_io.offset[`SIOS_MINUS_STEER_BIT];
      cfg_io.cfg.plus_to_neg = cfg_io.offset[`SIOS_PLUS_STEER_BIT];
      cfg_io.cfg.minus_threshold_level =
         sios_thr_pct(cfg_io.sens[`SIOS_MINUS_THR_LSB +: 4]);
      cfg_io.cfg.plus_threshold_level =
         sios_thr_pct(cfg_io.sens[`SIOS_PLUS_THR_LSB +: 4]);
      cfg_io.cfg.minus_peak_level = sios_peak_pct(cfg_io.sens[`SIOS_MINUS_PEAK_LSB +: 3]);
      cfg_io.cfg.plus_peak_level = sios_peak_pct(cfg_io.sens[`SIOS_PLUS_PEAK_LSB +: 3]);
      cfg_io.cfg.minus_peak_ok = (cfg_io.sens[`SIOS_MINUS_PEAK_LSB +: 3] <= `SIOS_PEAK_MAX_CODE);
      cfg_io.cfg.plus_peak_ok = (cfg_io.sens[`SIOS_PLUS_PEAK_LSB +: 3] <= `SIOS_PEAK_MAX_CODE);
   end

endmodule

// ---- tb/sios_regs_checker.sv ----
// port assertions for the stage input, offset and sensitivity register bank
`timescale 1ns/1ps
`include "sios_params.svh"
module sios_regs_checker #(
   parameter int NUM_STAGES = `SIOS_NUM_STAGES
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [3:0] stage_sel,
   input wire logic [3:0] stage_cfg_idx,
   input wire sios_pkg::sios_stage_cfg_t stage_cfg
);
   logic [11:0] widx;
   logic unmapped;
   assign widx = haddr[13:2];
   assign unmapped = widx < `SIOS_STAGE_BASE_IDX || widx[2:0] == 3'h0
      || widx[2:0] > `SIOS_SLOT_SENS || widx >= `SIOS_STAGE_BASE_IDX + 8 * NUM_STAGES;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   // ****************************************************************
   // sequences and properties
   // ****************************************************************
   sequence s_rd_unmapped;
      hsel && hready && htrans == `SIOS_HTRANS_NONSEQ && !hwrite && unmapped;
   endsequence
   // no transfer and a steady select, long enough for any write to have landed
   sequence s_quiet;
      !(hsel && htrans == `SIOS_HTRANS_NONSEQ) && $stable(stage_sel);
   endsequence
   property p_unmapped_zero;
      s_rd_unmapped |=> hrdata == 32'h0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   property p_cfg_hold;
      s_quiet [*4] |=> $stable(stage_cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("stage config moved while idle");
   property p_idx_follow;
      stage_sel < NUM_STAGES |=> stage_cfg_idx == $past(stage_sel);
   endproperty
   a_idx_follow: assert property (p_idx_follow) else $error("shown stage not selected");
   property p_idx_wrap;
      stage_sel >= NUM_STAGES |=> stage_cfg_idx == 4'h0;
   endproperty
   a_idx_wrap: assert property (p_idx_wrap) else $error("out of range select not stage 0");
   property p_minus_ff;
      stage_cfg.minus_offset_ff == stage_cfg.minus_offset_code * `SIOS_OFFSET_STEP_FF;
   endproperty
   a_minus_ff: assert property (p_minus_ff) else $error("negative offset size wrong");
   property p_plus_ff;
      stage_cfg.plus_offset_ff == stage_cfg.plus_offset_code * `SIOS_OFFSET_STEP_FF;
   endproperty
   a_plus_ff: assert property (p_plus_ff) else $error("positive offset size wrong");
   property p_minus_peak;
      stage_cfg.minus_peak_ok ? stage_cfg.minus_peak_level inside {40, 50, 60, 70, 80, 90}
         : stage_cfg.minus_peak_level == 7'h0;
   endproperty
   a_minus_peak: assert property (p_minus_peak) else $error("negative peak level wrong");
   property p_diff;
      stage_cfg.diff == (stage_cfg.single_ended_mode_sel == sios_pkg::SIOS_SE_DIFF);
   endproperty
   a_diff: assert property (p_diff) else $error("differential flag wrong");
endmodule

bind sios_regs sios_regs_checker #(.NUM_STAGES(NUM_STAGES)) u_chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .stage_sel(stage_sel),
   .stage_cfg_idx(stage_cfg_idx), .stage_cfg(stage_cfg)
);

// ---- tb/sios_regs_test.sv ----
// self-checking bench for the stage register bank
`timescale 1ns/1ps
`include "sios_params.svh"
module sios_regs_test;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] stage_sel = 4'h0;
   logic hready, hreadyout, hresp;
   logic [31:0] hrdata, rd;
   logic [3:0] stage_cfg_idx;
   logic [15:0] rt;
   logic [5:0] pm, nm, bm;
   sios_pkg::sios_stage_cfg_t cfg;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [13:0] thr_tbl [16] = '{14'd2500, 14'd2973, 14'd3440, 14'd3908, 14'd4379, 14'd4847,
      14'd5315, 14'd5783, 14'd6251, 14'd6722, 14'd7190, 14'd7658, 14'd8128, 14'd8596,
      14'd9064, 14'd9532};

   sios_regs #(.NUM_STAGES(12)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .stage_sel(stage_sel), .stage_cfg_idx(stage_cfg_idx), .stage_cfg(cfg));

   assign hready = hreadyout;
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_mismatch++;
         final_report();
      end
   end

   // ****************************************************************
   // bus and compare tasks
   // ****************************************************************
   function automatic logic [31:0] adr(input int s, input int k);
      return 32'(4 * (`SIOS_STAGE_BASE_IDX + 8 * s + k));
   endfunction
   // starts on an edge of its own, so it may be called from any point in time
   task automatic bus_req(input logic [31:0] a, input logic wr, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= `SIOS_HTRANS_NONSEQ;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hready !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
   endtask
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_fld(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: field %h, expected %h", $time, got, exp);
      end
   endtask
   // decoded config lands one edge after the write; look mid-cycle after that
   task automatic cfg_wait();
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic final_report();
      $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int s = 0; s < 12; s++) begin
         bus_req(adr(s, 1), 1'b1, 32'h3000 + 32'h0111 * (s + 1));
         bus_req(adr(s, 2), 1'b1, 32'hffff - s);
         bus_req(adr(s, 3), 1'b1, 32'hd5d0 + s);
      end
      for (int s = 0; s < 12; s++) begin
         bus_req(adr(s, 1), 1'b0, 32'h0);
         chk_rd(rd, 32'h3000 + 32'h0111 * (s + 1));
         bus_req(adr(s, 2), 1'b0, 32'h0);
         chk_rd(rd, (32'hffff - s) & 32'hbfbf);
         bus_req(adr(s, 3), 1'b0, 32'h0);
         chk_rd(rd, 32'h5550 + s);
      end
      bus_req(adr(11, 3), 1'b1, 32'h1234);
      bus_req(adr(11, 3), 1'b0, 32'h0);
      chk_rd(rd, 32'h1234);
      bus_req(adr(0, 0), 1'b1, 32'hffff);
      bus_req(adr(0, 0), 1'b0, 32'h0);
      chk_rd(rd, 32'h0);
      bus_req(adr(12, 1), 1'b0, 32'h0);
      chk_rd(rd, 32'h0);
      bus_req(adr(0, 4), 1'b0, 32'h0);
      chk_rd(rd, 32'h0);
      chk_fld(32'({hreadyout, hresp}), 32'h2);
      stage_sel <= 4'h5;
      for (int r = 0; r < 4; r++) begin
         rt = {r[1], r[0], 2'(r % 3 + 1), 12'h0};
         for (int i = 0; i < 6; i++) begin
            rt[2 * i +: 2] = 2'(i + r);
            pm[i] = 2'(i + r) == 2'h2;
            nm[i] = 2'(i + r) == 2'h1;
            bm[i] = 2'(i + r) == 2'h3;
         end
         bus_req(adr(5, 1), 1'b1, {16'h0, rt});
         bus_req(adr(5, 2), 1'b1, {16'h0, r[1], 1'b0, 6'(63 - 21 * r), r[0], 1'b0, 6'(21 * r)});
         cfg_wait();
         chk_fld(32'(stage_cfg_idx), 32'h5);
         chk_fld(32'({cfg.pos_mask, cfg.neg_mask, cfg.bias_mask}), 32'({pm, nm, bm}));
         chk_fld(32'(cfg.single_ended_mode_sel), 32'(r % 3 + 1));
         chk_fld(32'(cfg.diff), 32'(r % 3 == 2));
         chk_fld(32'({cfg.minus_on, cfg.plus_on}), 32'({~r[0], ~r[1]}));
         chk_fld({cfg.minus_offset_code, cfg.minus_offset_ff}, {6'(21 * r), 15'(6720 * r)});
         chk_fld({cfg.plus_offset_code, cfg.plus_offset_ff},
            {6'(63 - 21 * r), 15'(320 * (63 - 21 * r))});
         chk_fld(32'({cfg.minus_to_pos, cfg.plus_to_neg}), 32'({r[0], r[1]}));
      end
      for (int c = 0; c < 16; c++) begin
         bus_req(adr(5, 3), 1'b1,
            {17'h0, 3'(c % 6), 4'(15 - c), 1'b0, 3'(5 - c % 6), 4'(c)});
         cfg_wait();
         chk_fld(32'(cfg.minus_threshold_level), 32'(thr_tbl[c]));
         chk_fld(32'(cfg.plus_threshold_level), 32'(thr_tbl[15 - c]));
         chk_fld(32'({cfg.minus_peak_ok, cfg.minus_peak_level}), {1'b1, 7'(90 - 10 * (c % 6))});
         chk_fld(32'({cfg.plus_peak_ok, cfg.plus_peak_level}), {1'b1, 7'(40 + 10 * (c % 6))});
      end
      // a quiet stretch with a steady select lets the hold property fire
      repeat (6) @(posedge ref_clk);
      stage_sel <= 4'hd;
      cfg_wait();
      chk_fld(32'(stage_cfg_idx), 32'h0);
      final_report();
   end
endmodule
